// [hw/pmcr_pkg.sv]
package pmcr_pkg;

  // APB side
  localparam int          PMCR_AW          = 12;
  localparam int          PMCR_DW          = 32;
  localparam logic [11:0] PMCR_OFS_CONTROL = 12'h000;
  localparam logic [11:0] PMCR_OFS_STATUS  = 12'h004;

  // Reset values
  localparam logic [31:0] PMCR_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] PMCR_STATUS_RESET  = 32'h0000_0000;

  // power_control field positions
  localparam int CTL_STOP_LP    = 0;
  localparam int CTL_DS_TARGET  = 1;
  localparam int CTL_WAKE_CLR   = 2;
  localparam int CTL_SB_CLR     = 3;
  localparam int CTL_DET_EN     = 4;
  localparam int CTL_THR_LSB    = 5;
  localparam int CTL_THR_MSB    = 7;
  localparam int CTL_BKP_UNLOCK = 8;
  localparam int CTL_FLASH_OFF  = 9;
  localparam int CTL_SCALE_SEL  = 14;

  // power_control_status field positions
  localparam int STS_WAKE      = 0;
  localparam int STS_SB        = 1;
  localparam int STS_BELOW     = 2;
  localparam int STS_BKP_RDY   = 3;
  localparam int STS_PIN_CFG   = 8;
  localparam int STS_BKPR_EN   = 9;
  localparam int STS_SCALE_RDY = 14;

  // Cycles from the clear write to the wake flag dropping
  localparam int WAKE_CLR_DELAY = 2;

  // Asynchronous inputs, synchronised as one bundle
  localparam int PMCR_ASYNC_W = 8;

  typedef struct packed {
    logic       scale_sel;
    logic       flash_off;
    logic       bkp_unlock;
    logic [2:0] threshold;
    logic       det_en;
    logic       ds_target;
    logic       stop_lp;
  } pmcr_ctrl_t;

  localparam pmcr_ctrl_t PMCR_CTRL_RESET = '0;

  typedef struct packed {
    logic scale_ready;
    logic bkp_ready;
    logic supply_below;
    logic rtc_wakeup;
    logic rtc_stamp;
    logic rtc_tamper;
    logic rtc_alarm;
    logic wake_pin;
  } pmcr_async_t;

  typedef enum logic [1:0] {
    PMCR_S_IDLE,
    PMCR_S_WAIT,
    PMCR_S_READY
  } pmcr_apb_state_t;

endpackage

// [hw/pmcr_sync.sv]
`timescale 1ns/1ps
module pmcr_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // Each bit has its own two-stage chain; nothing reads meta_reg but stage 2
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule

// [hw/pmcr_top.sv]
// How it works
// R1 - Control register resets to zero and clears on standby wake-up.
// R2 - Control bit 0 puts the stop-mode regulator in low-power mode.
// R3 - Control bit 1 picks standby, else stop, as the deep-sleep target.
// R4 - Writing 1 to control bit 2 clears the wake flag two cycles later.
// R5 - Writing 1 to control bit 3 clears the standby flag.
// R6 - Control bit 4 enables the supply voltage detector.
// R7 - Control bits 7:5 select one of eight detector thresholds.
// R8 - Control bit 8 unlocks backup domain writes; locked after reset.
// R9 - Control bit 9 powers flash down on entry to stop mode.
// R10 - Control bit 14 selects regulator scaling level 1 or 2.
// R11 - Status register resets to zero; reads take one extra APB cycle.
// R12 - Status bit 0 sets on any pin or RTC wake-up event.
// R13 - With the pin function enabled, a high wake pin is an event.
// R14 - Status bit 1 sets on standby entry; cleared by reset or clear bit.
// R15 - Status bit 2 shows supply below threshold while detector enabled.
// R16 - Detector flag is zero after reset and on standby entry.
// R17 - Status bit 3 shows backup regulator ready.
// R18 - Status bit 8 lets the wake pin wake the part from standby.
// R19 - Wake pin configuration clears on every system reset.
// R20 - Status bit 14 shows regulator scaling level ready.
// R21 - Software enters standby only with the wake flag cleared.
// R22 - Reserved bits ignore writes and read as zero.
`timescale 1ns/1ps
module pmcr_top
  import pmcr_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire logic               sys_reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PMCR_AW-1:0] paddr,
  input  wire logic [PMCR_DW-1:0] pwdata,
  output logic      [PMCR_DW-1:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               wake_pin,
  input  wire logic               rtc_alarm,
  input  wire logic               rtc_tamper,
  input  wire logic               rtc_stamp,
  input  wire logic               rtc_wakeup,
  input  wire logic               supply_below,
  input  wire logic               bkp_ready,
  input  wire logic               scale_ready,
  input  wire logic               deep_sleep_req,
  input  wire logic               standby_wake,
  output logic                    stop_entry,
  output logic                    standby_entry,
  output logic                    stop_regulator_lowpower,
  output logic                    deep_sleep_target_select,
  output logic                    supply_detector_enable,
  output logic      [2:0]         supply_detector_threshold,
  output logic                    backup_write_unlock,
  output logic                    flash_off_in_stop,
  output logic                    regulator_scaling_select,
  output logic                    wake_pin_function_select,
  output logic                    backup_regulator_enable
);

  pmcr_apb_state_t             state_reg;
  pmcr_apb_state_t             state_next;
  pmcr_ctrl_t                  ctrl_reg;
  pmcr_ctrl_t                  ctrl_wdata;
  pmcr_async_t                 async_bus;
  pmcr_async_t                 sync_bus;
  logic                        wake_flag_reg;
  logic                        sb_flag_reg;
  logic                        below_flag_reg;
  logic                        bkp_rdy_reg;
  logic                        scale_rdy_reg;
  logic                        pin_cfg_reg;
  logic                        bkpr_en_reg;
  logic [WAKE_CLR_DELAY-1:0]   wake_clr_pipe_reg;
  logic [PMCR_DW-1:0]          prdata_reg;
  logic                        pready_reg;
  logic                        pslverr_reg;
  logic                        stop_entry_reg;
  logic                        standby_entry_reg;

  logic                        setup_phase;
  logic                        commit;
  logic                        hit_ctrl;
  logic                        hit_sts;
  logic                        hit_none;
  logic                        wr_ctrl;
  logic                        wr_sts;
  logic                        wake_event;
  logic                        wake_clr_now;
  logic                        sb_clr_req;
  logic                        go_standby;
  logic                        go_stop;
  logic [PMCR_DW-1:0]          ctrl_rdata;
  logic [PMCR_DW-1:0]          sts_rdata;

  assign async_bus.wake_pin     = wake_pin;
  assign async_bus.rtc_alarm    = rtc_alarm;
  assign async_bus.rtc_tamper   = rtc_tamper;
  assign async_bus.rtc_stamp    = rtc_stamp;
  assign async_bus.rtc_wakeup   = rtc_wakeup;
  assign async_bus.supply_below = supply_below;
  assign async_bus.bkp_ready    = bkp_ready;
  assign async_bus.scale_ready  = scale_ready;

  pmcr_sync #(
    .W (PMCR_ASYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (async_bus),
    .sync_out (sync_bus)
  );

  // Address decode; all twelve paddr bits are compared, so upper bits must be zero
  assign setup_phase = psel && !penable && (state_reg == PMCR_S_IDLE);
  assign commit      = psel && penable && (state_reg == PMCR_S_READY);
  assign hit_ctrl    = (paddr == PMCR_OFS_CONTROL);
  assign hit_sts     = (paddr == PMCR_OFS_STATUS);
  assign hit_none    = !hit_ctrl && !hit_sts;
  assign wr_ctrl     = commit && pwrite && hit_ctrl;
  assign wr_sts      = commit && pwrite && hit_sts;

  // Only the named fields are kept; other written bits are dropped
  assign ctrl_wdata.stop_lp    = pwdata[CTL_STOP_LP];                  // R2
  assign ctrl_wdata.ds_target  = pwdata[CTL_DS_TARGET];                // R3
  assign ctrl_wdata.det_en     = pwdata[CTL_DET_EN];                   // R6
  assign ctrl_wdata.threshold  = pwdata[CTL_THR_MSB:CTL_THR_LSB];      // R7
  assign ctrl_wdata.bkp_unlock = pwdata[CTL_BKP_UNLOCK];               // R8
  assign ctrl_wdata.flash_off  = pwdata[CTL_FLASH_OFF];                // R9
  assign ctrl_wdata.scale_sel  = pwdata[CTL_SCALE_SEL];                // R10

  // Trigger bits act only on a 1; they are never stored
  assign sb_clr_req   = wr_ctrl && pwdata[CTL_SB_CLR];                 // R5
  assign wake_clr_now = wake_clr_pipe_reg[WAKE_CLR_DELAY-1];           // R4

  // Pin counts only when its wake function is selected
  assign wake_event = (sync_bus.wake_pin && pin_cfg_reg)               // R13
                   || sync_bus.rtc_alarm
                   || sync_bus.rtc_tamper
                   || sync_bus.rtc_stamp
                   || sync_bus.rtc_wakeup;                             // R12

  // Standby is held off while a wake event is pending, else it would
  // wake at once; the request is then dropped, not turned into stop
  assign go_standby = deep_sleep_req && ctrl_reg.ds_target
                   && !wake_flag_reg;                                  // R21
  assign go_stop    = deep_sleep_req && !ctrl_reg.ds_target;           // R3

  always_comb begin
    ctrl_rdata                             = '0;                       // R22
    ctrl_rdata[CTL_STOP_LP]                = ctrl_reg.stop_lp;
    ctrl_rdata[CTL_DS_TARGET]              = ctrl_reg.ds_target;
    ctrl_rdata[CTL_DET_EN]                 = ctrl_reg.det_en;
    ctrl_rdata[CTL_THR_MSB:CTL_THR_LSB]    = ctrl_reg.threshold;
    ctrl_rdata[CTL_BKP_UNLOCK]             = ctrl_reg.bkp_unlock;
    ctrl_rdata[CTL_FLASH_OFF]              = ctrl_reg.flash_off;
    ctrl_rdata[CTL_SCALE_SEL]              = ctrl_reg.scale_sel;
  end

  always_comb begin
    sts_rdata                = '0;                                     // R22
    sts_rdata[STS_WAKE]      = wake_flag_reg;
    sts_rdata[STS_SB]        = sb_flag_reg;
    sts_rdata[STS_BELOW]     = below_flag_reg;
    sts_rdata[STS_BKP_RDY]   = bkp_rdy_reg;
    sts_rdata[STS_PIN_CFG]   = pin_cfg_reg;
    sts_rdata[STS_BKPR_EN]   = bkpr_en_reg;
    sts_rdata[STS_SCALE_RDY] = scale_rdy_reg;
  end

  // APB slave: status reads pass through one wait state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PMCR_S_IDLE: begin
        if (setup_phase) begin
          if (!pwrite && hit_sts) begin
            state_next = PMCR_S_WAIT;                                  // R11
          end else begin
            state_next = PMCR_S_READY;
          end
        end
      end
      PMCR_S_WAIT: begin
        state_next = PMCR_S_READY;
      end
      PMCR_S_READY: begin
        state_next = PMCR_S_IDLE;
      end
      default: begin
        state_next = PMCR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= PMCR_S_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      pready_reg  <= (state_next == PMCR_S_READY);
      if (setup_phase) begin
        pslverr_reg <= hit_none;
        prdata_reg  <= (!pwrite && hit_ctrl) ? ctrl_rdata : '0;
      end else if (state_reg == PMCR_S_WAIT) begin
        prdata_reg  <= sts_rdata;                                      // R11
      end else if (state_reg == PMCR_S_READY) begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= '0;
      end
    end
  end

  // Control register; standby wake-up and system reset both clear it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= PMCR_CTRL_RESET;                                     // R1
    end else if (standby_wake || sys_reset) begin
      ctrl_reg <= PMCR_CTRL_RESET;                                     // R1
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_wdata;
    end
  end

  // Clear request walks a short pipe so the flag drops two cycles late
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_clr_pipe_reg <= '0;
    end else begin
      wake_clr_pipe_reg <= {wake_clr_pipe_reg[WAKE_CLR_DELAY-2:0],
                            wr_ctrl && pwdata[CTL_WAKE_CLR]};          // R4
    end
  end

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_flag_reg <= 1'b0;
    end else if (wake_event) begin
      wake_flag_reg <= 1'b1;                                           // R12
    end else if (wake_clr_now) begin
      wake_flag_reg <= 1'b0;                                           // R4
    end
  end

  // Standby flag survives system reset; only rst_b or the clear bit drop it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sb_flag_reg <= 1'b0;
    end else if (standby_entry_reg) begin
      sb_flag_reg <= 1'b1;                                             // R14
    end else if (sb_clr_req) begin
      sb_flag_reg <= 1'b0;                                             // R5
    end
  end

  // Detector reads as zero while disabled and is cleared on standby entry
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      below_flag_reg <= 1'b0;                                          // R16
    end else if (standby_entry_reg) begin
      below_flag_reg <= 1'b0;                                          // R16
    end else begin
      below_flag_reg <= ctrl_reg.det_en && sync_bus.supply_below;      // R15
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bkp_rdy_reg   <= 1'b0;
      scale_rdy_reg <= 1'b0;
    end else begin
      bkp_rdy_reg   <= sync_bus.bkp_ready;                             // R17
      scale_rdy_reg <= sync_bus.scale_ready;                           // R20
    end
  end

  // Writable status bits; read-only flags ignore the write
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_cfg_reg <= 1'b0;
      bkpr_en_reg <= 1'b0;
    end else if (sys_reset) begin
      pin_cfg_reg <= 1'b0;                                             // R19
    end else if (wr_sts) begin
      pin_cfg_reg <= pwdata[STS_PIN_CFG];                              // R18
      bkpr_en_reg <= pwdata[STS_BKPR_EN];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_entry_reg    <= 1'b0;
      standby_entry_reg <= 1'b0;
    end else begin
      stop_entry_reg    <= go_stop;                                    // R3
      standby_entry_reg <= go_standby;                                 // R3
    end
  end

  assign prdata                    = prdata_reg;
  assign pready                    = pready_reg;
  assign pslverr                   = pslverr_reg;
  assign stop_entry                = stop_entry_reg;
  assign standby_entry             = standby_entry_reg;
  assign stop_regulator_lowpower   = ctrl_reg.stop_lp;                 // R2
  assign deep_sleep_target_select  = ctrl_reg.ds_target;
  assign supply_detector_enable    = ctrl_reg.det_en;                  // R6
  assign supply_detector_threshold = ctrl_reg.threshold;               // R7
  assign backup_write_unlock       = ctrl_reg.bkp_unlock;              // R8
  assign flash_off_in_stop         = ctrl_reg.flash_off;               // R9
  assign regulator_scaling_select  = ctrl_reg.scale_sel;               // R10
  assign wake_pin_function_select  = pin_cfg_reg;                      // R18
  assign backup_regulator_enable   = bkpr_en_reg;

endmodule

// [dv/pmcr_props.sv]
`timescale 1ns/1ps
module pmcr_props
  import pmcr_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_b,
  input wire logic               sys_reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PMCR_AW-1:0] paddr,
  input wire logic [PMCR_DW-1:0] pwdata,
  input wire logic [PMCR_DW-1:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               deep_sleep_req,
  input wire logic               standby_wake,
  input wire logic               stop_entry,
  input wire logic               standby_entry,
  input wire logic               stop_regulator_lowpower,
  input wire logic               deep_sleep_target_select,
  input wire logic               supply_detector_enable,
  input wire logic [2:0]         supply_detector_threshold,
  input wire logic               backup_write_unlock,
  input wire logic               flash_off_in_stop,
  input wire logic               regulator_scaling_select,
  input wire logic               wake_pin_function_select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire       acc    = psel && penable;
  wire       is_ctl = paddr == PMCR_OFS_CONTROL;
  wire       is_sts = paddr == PMCR_OFS_STATUS;
  wire [8:0] ctl    = {regulator_scaling_select, flash_off_in_stop,
                       backup_write_unlock, supply_detector_threshold,
                       supply_detector_enable, deep_sleep_target_select,
                       stop_regulator_lowpower};
  wire [8:0] wf     = {pwdata[14], pwdata[9:4], pwdata[1:0]};
  wire [8:0] rf     = {prdata[14], prdata[9:4], prdata[1:0]};

  ctrl_nowait_a: assert property (
    acc && is_ctl && !$past(penable) |-> pready && !pslverr)
    else $error("control access not answered at once");
  status_wait_a: assert property (
    acc && !pwrite && is_sts && !$past(penable) |-> !pready ##1 pready)
    else $error("status read wait state wrong");
  unmapped_err_a: assert property (
    pready && !is_ctl && !is_sts |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  idle_quiet_a: assert property (
    !pready |-> prdata == '0 && !pslverr)
    else $error("read bus not quiet");
  ctrl_read_a: assert property (
    pready && !pwrite && is_ctl |-> rf == ctl && prdata[31:15] == '0
      && prdata[13:10] == '0 && prdata[3:2] == '0)
    else $error("control read disagrees with outputs");
  ctrl_write_a: assert property (
    pready && pwrite && is_ctl && !sys_reset && !standby_wake
      |=> ctl == $past(wf))
    else $error("control write not applied");
  sys_clear_a: assert property (
    sys_reset |=> ctl == '0 && !wake_pin_function_select)
    else $error("system reset did not clear");
  wake_clear_a: assert property (
    standby_wake |=> ctl == '0)
    else $error("standby wake did not clear control");
  stop_pick_a: assert property (
    deep_sleep_req && !deep_sleep_target_select
      |=> stop_entry && !standby_entry)
    else $error("stop entry missing");
  standby_cause_a: assert property (
    standby_entry |-> $past(deep_sleep_req)
      && $past(deep_sleep_target_select))
    else $error("standby entry without cause");
endmodule

bind pmcr_top pmcr_props u_props (
  .core_clk, .rst_b, .sys_reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .deep_sleep_req, .standby_wake,
  .stop_entry, .standby_entry, .stop_regulator_lowpower,
  .deep_sleep_target_select, .supply_detector_enable,
  .supply_detector_threshold, .backup_write_unlock, .flash_off_in_stop,
  .regulator_scaling_select, .wake_pin_function_select
);

// [dv/pmcr_apb_host.sv]
`timescale 1ns/1ps
module pmcr_apb_host
  import pmcr_pkg::*;
(
  input  wire logic               core_clk,
  output logic                    psel,
  output logic                    penable,
  output logic                    pwrite,
  output logic      [PMCR_AW-1:0] paddr,
  output logic      [PMCR_DW-1:0] pwdata,
  input  wire logic [PMCR_DW-1:0] prdata,
  input  wire logic               pready,
  input  wire logic               pslverr
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
  end

  // Held from setup until pready is seen high on a rising edge, giving up after eight rising edges
  task automatic xfer(input logic w, input logic [PMCR_AW-1:0] a,
                      input logic [PMCR_DW-1:0] v,
                      output logic [PMCR_DW-1:0] r, output logic e);
    int n;
    @(negedge core_clk);
    {psel, penable, pwrite} = {2'b10, w};
    paddr = a;
    pwdata = v;
    @(negedge core_clk);
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    r = (pready === 1'b1) ? prdata : 'x;
    e = pslverr;
  endtask

  // Released lines flip so a stale value can never look valid
  task automatic idle();
    @(negedge core_clk);
    {psel, penable} = 2'b00;
    paddr = ~paddr;
    pwdata = ~pwdata;
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  import pmcr_pkg::*;
  logic               core_clk       = 1'b0;
  logic               rst_b          = 1'b0;
  logic               sys_reset      = 1'b0;
  logic               deep_sleep_req = 1'b0;
  logic               standby_wake   = 1'b0;
  logic               supply_below   = 1'b0;
  logic               bkp_ready      = 1'b0;
  logic               scale_ready    = 1'b0;
  logic [4:0]         wk             = 5'h00;
  logic               psel, penable, pwrite, pready, pslverr, err;
  logic               stop_entry, standby_entry, pcfg, bken;
  wire  [8:0]         ctl;
  logic [PMCR_AW-1:0] paddr;
  logic [PMCR_DW-1:0] pwdata, prdata, rd, d;
  logic               mw, ms, mb, mk, me, mc, mv;
  int                 bad_count      = 0;
  int                 checks_done    = 0;
  int                 cyc            = 0;

  always #5 core_clk = ~core_clk;

  pmcr_top uut (
    .core_clk, .rst_b, .sys_reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .wake_pin(wk[0]),
    .rtc_alarm(wk[1]), .rtc_tamper(wk[2]), .rtc_stamp(wk[3]),
    .rtc_wakeup(wk[4]), .supply_below, .bkp_ready, .scale_ready,
    .deep_sleep_req, .standby_wake, .stop_entry, .standby_entry,
    .stop_regulator_lowpower(ctl[0]), .deep_sleep_target_select(ctl[1]),
    .supply_detector_enable(ctl[2]), .supply_detector_threshold(ctl[5:3]),
    .backup_write_unlock(ctl[6]), .flash_off_in_stop(ctl[7]),
    .regulator_scaling_select(ctl[8]), .wake_pin_function_select(pcfg),
    .backup_regulator_enable(bken)
  );

  pmcr_apb_host host (
    .core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr
  );

  function automatic logic [31:0] exp_sts();
    return {17'h0, mv, 4'h0, me, mc, 4'h0, mk, mb, ms, mw};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, rd, err);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] v);
    host.xfer(1'b0, a, $urandom, rd, err);
    chk(rd, v);
  endtask

  task automatic gap(input int n);
    host.idle();
    repeat (n) @(negedge core_clk);
  endtask

  // Two cycles high so the synchroniser cannot miss it
  task automatic pulse(input int j);
    gap(0);
    wk[j] = 1'b1;
    repeat (2) @(negedge core_clk);
    wk[j] = 1'b0;
    repeat (5) @(negedge core_clk);
  endtask

  task automatic dsleep(input logic [1:0] e);
    gap(0);
    deep_sleep_req = 1'b1;
    @(negedge core_clk);
    deep_sleep_req = 1'b0;
    chk({30'h0, stop_entry, standby_entry}, {30'h0, e});
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    {mw, ms, mb, mk, me, mc, mv} = 7'h00;
    void'($urandom(95));
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    rdc(PMCR_OFS_CONTROL, 32'h0);
    rdc(PMCR_OFS_STATUS, 32'h0);
    done("reset");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hffff_ffff : $urandom;
      d[7:5] = i[2:0];
      wr(PMCR_OFS_CONTROL, d);
      rdc(PMCR_OFS_CONTROL, d & 32'h0000_43f3);
      chk({23'h0, ctl}, {23'h0, d[14], d[9:4], d[1:0]});
    end
    done("control");
    wr(PMCR_OFS_STATUS, 32'hffff_feff);
    me = 1'b1;
    rdc(PMCR_OFS_STATUS, exp_sts());
    chk({30'h0, pcfg, bken}, {30'h0, mc, me});
    done("status");
    pulse(0);
    rdc(PMCR_OFS_STATUS, exp_sts());
    wr(PMCR_OFS_STATUS, 32'h0000_0300);
    mc = 1'b1;
    for (int j = 0; j < 5; j++) begin
      pulse(j);
      mw = 1'b1;
      rdc(PMCR_OFS_STATUS, exp_sts());
      wr(PMCR_OFS_CONTROL, 32'h0000_0004);
      rdc(PMCR_OFS_STATUS, exp_sts());
      mw = 1'b0;
      rdc(PMCR_OFS_STATUS, exp_sts());
    end
    done("wake");
    wr(PMCR_OFS_CONTROL, 32'h0000_0001);
    dsleep(2'b10);
    wr(PMCR_OFS_CONTROL, 32'h0000_0002);
    dsleep(2'b01);
    ms = 1'b1;
    gap(2);
    rdc(PMCR_OFS_STATUS, exp_sts());
    wr(PMCR_OFS_CONTROL, 32'h0000_43f3);
    gap(0);
    sys_reset = 1'b1;
    @(negedge core_clk);
    sys_reset = 1'b0;
    mc = 1'b0;
    rdc(PMCR_OFS_CONTROL, 32'h0);
    rdc(PMCR_OFS_STATUS, exp_sts());
    chk({30'h0, pcfg, bken}, {30'h0, mc, me});
    wr(PMCR_OFS_CONTROL, 32'h0000_0002);
    rdc(PMCR_OFS_STATUS, exp_sts());
    wr(PMCR_OFS_CONTROL, 32'h0000_0008);
    ms = 1'b0;
    rdc(PMCR_OFS_STATUS, exp_sts());
    done("standby");
    gap(0);
    {supply_below, bkp_ready, scale_ready} = 3'h7;
    wr(PMCR_OFS_CONTROL, 32'h0000_0010);
    gap(5);
    {mb, mk, mv} = 3'h7;
    rdc(PMCR_OFS_STATUS, exp_sts());
    wr(PMCR_OFS_CONTROL, 32'h0);
    gap(5);
    mb = 1'b0;
    rdc(PMCR_OFS_STATUS, exp_sts());
    done("levels");
    wr(PMCR_OFS_STATUS, 32'h0000_0100);
    {mc, me} = 2'b10;
    wr(PMCR_OFS_CONTROL, 32'h0000_43f3);
    gap(0);
    standby_wake = 1'b1;
    @(negedge core_clk);
    standby_wake = 1'b0;
    rdc(PMCR_OFS_CONTROL, 32'h0);
    rdc(PMCR_OFS_STATUS, exp_sts());
    chk({30'h0, pcfg, bken}, {30'h0, mc, me});
    done("standby wake");
    host.xfer(1'b1, 12'h400, 32'hffff_ffff, rd, err);
    chk({31'h0, err}, 32'h1);
    host.xfer(1'b0, 12'h104, 32'h0, rd, err);
    chk({err, rd[30:0]}, 32'h8000_0000);
    rdc(PMCR_OFS_CONTROL, 32'h0);
    done("unmapped");
    gap(1);
    results();
  end
endmodule
